// File: verif/dio_pins_model.sv
`timescale 1ns/1ns
module dio_pins_model (
  // data the far side presents
  input  wire logic [15:0] din,
  // pins
  output logic [15:0]      in_pin,
  input  wire logic [15:0] out_pin_o,
  input  wire logic [15:0] out_pin_oe,
  output logic [15:0]      out_level
);
  // ==========================================
  // pin levels
  assign in_pin = ~din;
  // no on-board pull-up on outputs, so the far side supplies it
  assign out_level = (out_pin_oe & out_pin_o) | ~out_pin_oe;
endmodule

// File: verif/dio_port_bench.sv
`timescale 1ns/1ns
module dio_port_bench;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, perr, pready, pslverr, irq;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [15:0] din = 0, in_pin, out_pin_o, out_pin_oe, out_level;
  int          n_mismatch = 0, checked = 0, cyc = 0;
  initial forever #10 pclk = ~pclk;
  dio_port i_dio_port (
    .pclk       (pclk),
    .presetn    (presetn),
    .psel       (psel),
    .penable    (penable),
    .pwrite     (pwrite),
    .paddr      (paddr),
    .pwdata     (pwdata),
    .prdata     (prdata),
    .pready     (pready),
    .pslverr    (pslverr),
    .in_pin     (in_pin),
    .out_pin_o  (out_pin_o),
    .out_pin_oe (out_pin_oe),
    .irq        (irq)
  );
  dio_pins_model i_dio_pins_model (
    .din        (din),
    .in_pin     (in_pin),
    .out_pin_o  (out_pin_o),
    .out_pin_oe (out_pin_oe),
    .out_level  (out_level)
  );
  // ==========================================
  // helpers
  task automatic stop_test();
    $display("mismatches %0d checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_mismatch++;
      stop_test();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // an idle edge between transfers keeps each strobe to one assignment per step
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    perr = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic rc(input string nm, input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0000_0000);
    chk(nm, e, rd);
  endtask
  task automatic pins(input logic [15:0] v, input int n);
    din <= v;
    repeat (n) @(posedge pclk);
  endtask
  // ==========================================
  // scenarios
  task automatic t_reset();
    chk("oe", 32'h0000_0000, out_pin_oe);
    rc("out", dio_pkg::OFF_OUT_DATA, 32'h0000_0000);
    rc("in", dio_pkg::OFF_IN_DATA, 32'h0000_0000);
    rc("fcnt", dio_pkg::OFF_FILT_CNT, 32'h0000_0004);
  endtask
  task automatic t_out();
    xfer(1'b1, dio_pkg::OFF_OUT_DATA, 32'hffff_a5c3);
    rc("out", dio_pkg::OFF_OUT_DATA, 32'h0000_a5c3);
    chk("oe", 32'h0000_a5c3, out_pin_oe);
    chk("lvl", 32'h0000_5a3c, out_level);
    // a reset in mid-run must switch every driven output off again
    presetn <= 1'b0;
    @(posedge pclk);
    chk("oe", 32'h0000_0000, out_pin_oe);
    presetn <= 1'b1;
    rc("out", dio_pkg::OFF_OUT_DATA, 32'h0000_0000);
    chk("lvl", 32'h0000_ffff, out_level);
  endtask
  task automatic t_in();
    pins(16'hffff, 8);
    rc("in", dio_pkg::OFF_IN_DATA, 32'h0000_ffff);
    pins(16'h8421, 8);
    rc("in", dio_pkg::OFF_IN_DATA, 32'h0000_8421);
    pins(16'h0004, 8);
  endtask
  task automatic t_irq();
    xfer(1'b1, dio_pkg::OFF_EDGE_SEL, 32'h0000_0004);
    xfer(1'b1, dio_pkg::OFF_IRQ_EN, 32'h0000_0005);
    xfer(1'b1, dio_pkg::OFF_IRQ_CLR, 32'h0000_ffff);
    pins(16'h0006, 8);
    chk("irq", 32'h0000_0000, irq);
    rc("stat", dio_pkg::OFF_IRQ_STAT, 32'h0000_0000);
    pins(16'h0003, 8);
    chk("irq", 32'h0000_0001, irq);
    rc("stat", dio_pkg::OFF_IRQ_STAT, 32'h0000_0005);
    xfer(1'b1, dio_pkg::OFF_IRQ_CLR, 32'h0000_0001);
    rc("stat", dio_pkg::OFF_IRQ_STAT, 32'h0000_0004);
    chk("irq", 32'h0000_0001, irq);
    rc("clr", dio_pkg::OFF_IRQ_CLR, 32'h0000_0000);
    xfer(1'b1, dio_pkg::OFF_IRQ_EN, 32'h0000_0000);
    pins(16'h0000, 3);
    chk("irq", 32'h0000_0000, irq);
  endtask
  task automatic t_filt();
    xfer(1'b1, dio_pkg::OFF_FILT_SEL, 32'h0000_0001);
    xfer(1'b1, dio_pkg::OFF_IRQ_CLR, 32'h0000_ffff);
    xfer(1'b1, dio_pkg::OFF_EDGE_SEL, 32'h0000_0000);
    xfer(1'b1, dio_pkg::OFF_IRQ_EN, 32'h0000_0001);
    pins(16'h0001, 3);
    pins(16'h0000, 14);
    rc("stat", dio_pkg::OFF_IRQ_STAT, 32'h0000_0000);
    pins(16'h0001, 14);
    rc("in", dio_pkg::OFF_IN_DATA, 32'h0000_0001);
    rc("stat", dio_pkg::OFF_IRQ_STAT, 32'h0000_0001);
  endtask
  task automatic t_bad();
    rc("bad", 12'h020, 32'h0000_0000);
    chk("err", 32'h0000_0001, perr);
  endtask
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_out();
    t_in();
    t_irq();
    t_filt();
    t_bad();
    stop_test();
  end
endmodule

// File: verif/dio_port_sva.sv
`timescale 1ns/1ns
module dio_port_sva (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // pins
  input wire logic [15:0] in_pin,
  input wire logic [15:0] out_pin_o,
  input wire logic [15:0] out_pin_oe,
  input wire logic        irq
);
  // ==========================================
  // bus and pin checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc = psel & penable;
  wire wra = acc & pwrite;
  property p_rdy; pready; endproperty
  a_rdy: assert property (p_rdy) else $error("pready low");
  property p_err; acc && paddr > dio_pkg::OFF_FILT_CNT |-> pslverr && (pwrite || prdata == 32'h0000_0000); endproperty
  a_err: assert property (p_err) else $error("unmapped access not refused");
  property p_ok; acc && paddr[1:0] == 2'b00 && paddr <= dio_pkg::OFF_FILT_CNT |-> !pslverr; endproperty
  a_ok: assert property (p_ok) else $error("mapped access refused");
  property p_hi; acc && !pwrite |-> prdata[31:16] == 16'h0000; endproperty
  a_hi: assert property (p_hi) else $error("upper read bits set");
  property p_out; wra && paddr == dio_pkg::OFF_OUT_DATA |=> out_pin_oe == $past(pwdata[15:0]); endproperty
  a_out: assert property (p_out) else $error("output write lost");
  // outputs may move only by a host write or a reset, never on their own
  property p_hold; !$stable(out_pin_oe) |-> $past(wra && paddr == dio_pkg::OFF_OUT_DATA); endproperty
  a_hold: assert property (p_hold) else $error("outputs changed unasked");
  property p_od; out_pin_o == 16'h0000; endproperty
  a_od: assert property (p_od) else $error("open-collector drives high");
  property p_en0; wra && paddr == dio_pkg::OFF_IRQ_EN && pwdata[15:0] == 16'h0000 |=> ##1 !irq; endproperty
  a_en0: assert property (p_en0) else $error("irq with all disabled");
endmodule
bind dio_port dio_port_sva i_dio_port_sva (
  .pclk       (pclk),
  .presetn    (presetn),
  .psel       (psel),
  .penable    (penable),
  .pwrite     (pwrite),
  .paddr      (paddr),
  .pwdata     (pwdata),
  .prdata     (prdata),
  .pready     (pready),
  .pslverr    (pslverr),
  .in_pin     (in_pin),
  .out_pin_o  (out_pin_o),
  .out_pin_oe (out_pin_oe),
  .irq        (irq)
);

// File: verilog/dio_filter.sv
`timescale 1ns/1ns
module dio_filter #(
  parameter int W = dio_pkg::FILT_W
) (
  // clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // control
  input  wire logic         bypass,
  input  wire logic [W-1:0] stable_cycles,
  // data
  input  wire logic         raw,
  output logic              filt
);
  // ==========================================
  // state
  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;
  logic         filt_reg;
  logic         filt_next;

  // a new level is accepted only after it holds steady for stable_cycles+1 clocks
  always_comb begin
    cnt_next  = cnt_reg;
    filt_next = filt_reg;
    if (bypass) begin
      cnt_next  = '0;
      filt_next = raw;
    end else if (raw == filt_reg) begin
      cnt_next = '0;
    end else if (cnt_reg >= stable_cycles) begin
      cnt_next  = '0;
      filt_next = raw;
    end else begin
      cnt_next = cnt_reg + W'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg  <= '0;
      filt_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      filt_reg <= filt_next;
    end
  end

  assign filt = filt_reg;
endmodule

// File: verilog/dio_pkg.sv
package dio_pkg;
  // ==========================================
  // register byte offsets
  localparam logic [11:0] OFF_IN_DATA   = 12'h000;
  localparam logic [11:0] OFF_OUT_DATA  = 12'h004;
  localparam logic [11:0] OFF_EDGE_SEL  = 12'h008;
  localparam logic [11:0] OFF_IRQ_EN    = 12'h00C;
  localparam logic [11:0] OFF_IRQ_STAT  = 12'h010;
  localparam logic [11:0] OFF_IRQ_CLR   = 12'h014;
  localparam logic [11:0] OFF_FILT_SEL  = 12'h018;
  localparam logic [11:0] OFF_FILT_CNT  = 12'h01C;
  // ==========================================
  // reset values
  localparam logic [15:0] RST_OUT       = 16'h0000;
  localparam logic [15:0] RST_EDGE      = 16'h0000;
  localparam logic [15:0] RST_IRQ_EN    = 16'h0000;
  localparam logic [15:0] RST_FILT_SEL  = 16'h0000;
  localparam logic [15:0] RST_FILT_CNT  = 16'h0004;
  localparam logic [15:0] RST_IN        = 16'h0000;
  // ==========================================
  // sizes
  localparam int          CHANNELS      = 16;
  localparam int          FILT_W        = 16;
endpackage

// File: verilog/dio_port.sv
`timescale 1ns/1ns
module dio_port #(
  parameter int N = dio_pkg::CHANNELS,
  parameter int W = dio_pkg::FILT_W
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // input pins
  input  wire logic [N-1:0] in_pin,
  // open-collector output pins
  output logic [N-1:0]     out_pin_o,
  output logic [N-1:0]     out_pin_oe,
  // interrupt
  output logic             irq
);
  // ==========================================
  // host-visible register state
  logic [N-1:0] out_reg;
  logic [N-1:0] out_next;
  logic [N-1:0] edge_reg;
  logic [N-1:0] edge_next;
  logic [N-1:0] en_reg;
  logic [N-1:0] en_next;
  logic [N-1:0] fsel_reg;
  logic [N-1:0] fsel_next;
  logic [W-1:0] fcnt_reg;
  logic [W-1:0] fcnt_next;
  logic [N-1:0] stat_reg;
  logic [N-1:0] stat_next;

  // ==========================================
  // input path state
  logic [N-1:0] sync1_reg;
  logic [N-1:0] sync1_next;
  logic [N-1:0] sync2_reg;
  logic [N-1:0] sync2_next;
  logic [N-1:0] prev_reg;
  logic [N-1:0] prev_next;

  // ==========================================
  // read path state
  logic [31:0]  rdata_reg;
  logic [31:0]  rdata_next;
  logic         err_reg;
  logic         err_next;

  // ==========================================
  // combinational nets
  logic [N-1:0] data_in;
  logic [N-1:0] filt_in;
  logic [N-1:0] rise;
  logic [N-1:0] fall;
  logic [N-1:0] hit;
  logic [N-1:0] clr_mask;
  logic         setup;
  logic         wr;
  logic         rd;
  logic         known;
  logic         sel_in;
  logic         sel_out;
  logic         sel_edge;
  logic         sel_en;
  logic         sel_stat;
  logic         sel_clr;
  logic         sel_fsel;
  logic         sel_fcnt;

  // ==========================================
  // input path: two-flop sync, invert, filter
  // pins are asynchronous, so logic reads only the second stage
  always_comb begin
    sync1_next = in_pin;
    sync2_next = sync1_reg;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // pin high is data zero, so release shows no false edge
      sync1_reg <= '1;
      sync2_reg <= '1;
    end else begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
    end
  end

  assign data_in = ~sync2_reg;

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_filt
      dio_filter #(
        .W(W)
      ) u_filt (
        .pclk          (pclk),
        .presetn       (presetn),
        .bypass        (~fsel_reg[g]),
        .stable_cycles (fcnt_reg),
        .raw           (data_in[g]),
        .filt          (filt_in[g])
      );
    end
  endgenerate

  // ==========================================
  // edge detection on filtered data
  always_comb begin
    prev_next = filt_in;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_reg <= N'(dio_pkg::RST_IN);
    end else begin
      prev_reg <= prev_next;
    end
  end

  // edge_reg bit 0 picks rising data edge, 1 picks falling
  genvar b;
  generate
    for (b = 0; b < N; b++) begin : g_edge
      assign rise[b] = filt_in[b] & ~prev_reg[b];
      assign fall[b] = ~filt_in[b] & prev_reg[b];
      assign hit[b]  = (edge_reg[b] ? fall[b] : rise[b]) & en_reg[b];
    end
  endgenerate

  // ==========================================
  // apb decode; zero wait states, so pready is tied high
  assign setup = psel & ~penable;
  assign wr    = psel & penable & pwrite;
  assign rd    = setup & ~pwrite;

  always_comb begin
    sel_in   = 1'b0;
    sel_out  = 1'b0;
    sel_edge = 1'b0;
    sel_en   = 1'b0;
    sel_stat = 1'b0;
    sel_clr  = 1'b0;
    sel_fsel = 1'b0;
    sel_fcnt = 1'b0;
    case (paddr)
      dio_pkg::OFF_IN_DATA:  sel_in   = 1'b1;
      dio_pkg::OFF_OUT_DATA: sel_out  = 1'b1;
      dio_pkg::OFF_EDGE_SEL: sel_edge = 1'b1;
      dio_pkg::OFF_IRQ_EN:   sel_en   = 1'b1;
      dio_pkg::OFF_IRQ_STAT: sel_stat = 1'b1;
      dio_pkg::OFF_IRQ_CLR:  sel_clr  = 1'b1;
      dio_pkg::OFF_FILT_SEL: sel_fsel = 1'b1;
      dio_pkg::OFF_FILT_CNT: sel_fcnt = 1'b1;
      default:               sel_in   = 1'b0;
    endcase
  end

  // unmapped and misaligned addresses select nothing and are refused
  assign known = sel_in | sel_out | sel_edge | sel_en | sel_stat | sel_clr | sel_fsel | sel_fcnt;

  // ==========================================
  // output latch
  always_comb begin
    out_next = out_reg;
    if (wr && sel_out) begin
      out_next = pwdata[N-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_reg <= N'(dio_pkg::RST_OUT);
    end else begin
      out_reg <= out_next;
    end
  end

  // ==========================================
  // host-written configuration
  always_comb begin
    edge_next = edge_reg;
    en_next   = en_reg;
    fsel_next = fsel_reg;
    fcnt_next = fcnt_reg;
    if (wr && sel_edge) begin
      edge_next = pwdata[N-1:0];
    end
    if (wr && sel_en) begin
      en_next = pwdata[N-1:0];
    end
    if (wr && sel_fsel) begin
      fsel_next = pwdata[N-1:0];
    end
    if (wr && sel_fcnt) begin
      fcnt_next = pwdata[W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      edge_reg <= N'(dio_pkg::RST_EDGE);
      en_reg   <= N'(dio_pkg::RST_IRQ_EN);
      fsel_reg <= N'(dio_pkg::RST_FILT_SEL);
      fcnt_reg <= W'(dio_pkg::RST_FILT_CNT);
    end else begin
      edge_reg <= edge_next;
      en_reg   <= en_next;
      fsel_reg <= fsel_next;
      fcnt_reg <= fcnt_next;
    end
  end

  // ==========================================
  // sticky pending flags, cleared by writing ones
  assign clr_mask = (wr && sel_clr) ? pwdata[N-1:0] : '0;

  always_comb begin
    // set wins over a clear landing in the same cycle
    stat_next = (stat_reg & ~clr_mask) | hit;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_reg <= N'(dio_pkg::RST_IN);
    end else begin
      stat_reg <= stat_next;
    end
  end

  // ==========================================
  // refusal flag, raised in setup and shown in access
  always_comb begin
    err_next = 1'b0;
    if (setup) begin
      err_next = ~known;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_reg <= 1'b0;
    end else begin
      err_reg <= err_next;
    end
  end

  // ==========================================
  // read data, captured in setup so it stands through access
  always_comb begin
    rdata_next = rdata_reg;
    if (rd) begin
      rdata_next = 32'h0000_0000;
      case (paddr)
        dio_pkg::OFF_IN_DATA:  rdata_next[N-1:0] = filt_in;
        dio_pkg::OFF_OUT_DATA: rdata_next[N-1:0] = out_reg;
        dio_pkg::OFF_EDGE_SEL: rdata_next[N-1:0] = edge_reg;
        dio_pkg::OFF_IRQ_EN:   rdata_next[N-1:0] = en_reg;
        dio_pkg::OFF_IRQ_STAT: rdata_next[N-1:0] = stat_reg;
        dio_pkg::OFF_FILT_SEL: rdata_next[N-1:0] = fsel_reg;
        dio_pkg::OFF_FILT_CNT: rdata_next[W-1:0] = fcnt_reg;
        default:               rdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_reg <= 32'h0000_0000;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // ==========================================
  // outputs
  assign prdata     = rdata_reg;
  assign pready     = 1'b1;
  assign pslverr    = psel & penable & err_reg;
  // pin only ever sinks current, so the driven level is always low
  assign out_pin_o  = '0;
  assign out_pin_oe = out_reg;
  // status bits exist only for enabled edges, and disabling later masks them from irq
  assign irq        = |(stat_reg & en_reg);
endmodule
